// ### src/mcr_regs.vh
/*
  constants for the machine check reporting block: codes, frame slots,
  apb register offsets and field positions.
  assumes inclusion by bare name from the design files.
*/
`ifndef MCR_REGS_VH
`define MCR_REGS_VH

// ----------------------------------------
// machine check codes
// ----------------------------------------
`define MCR_CODE_MM_MISS 8'h08
`define MCR_CODE_MM_HIT 8'h09
`define MCR_CODE_IPL 8'h0a
`define MCR_CODE_STRING 8'h0b
`define MCR_CODE_TRAP 8'h0c
`define MCR_CODE_CSADDR 8'h0d
`define MCR_CODE_PCACHE 8'h10
`define MCR_CODE_BUS_RD 8'h11
`define MCR_CODE_BUS_WR 8'h12
`define MCR_CODE_BUS_UND 8'h13
`define MCR_CODE_NONE 8'h00

// ----------------------------------------
// cause vector bit positions (lowest wins)
// ----------------------------------------
`define MCR_NCAUSE 10
`define MCR_C_BUS_UND 0
`define MCR_C_BUS_WR 1
`define MCR_C_BUS_RD 2
`define MCR_C_PCACHE 3
`define MCR_C_CSADDR 4
`define MCR_C_TRAP 5
`define MCR_C_STRING 6
`define MCR_C_IPL 7
`define MCR_C_MM_HIT 8
`define MCR_C_MM_MISS 9

// ----------------------------------------
// frame slot indices (byte offset / 4)
// ----------------------------------------
`define MCR_SLOT_W 3
`define MCR_NSLOT 8
`define MCR_SLOT_COUNT 3'h0
`define MCR_SLOT_CODE 3'h1
`define MCR_SLOT_ADDR 3'h2
`define MCR_SLOT_PREF 3'h3
`define MCR_SLOT_INTS 3'h4
`define MCR_BYTE_COUNT 32'h00000018

// ----------------------------------------
// frame field positions
// ----------------------------------------
`define MCR_RESTART_BIT 31
`define MCR_CLKIE_FRAME_BIT 22
`define MCR_CLKIE_SRC_BIT 6
`define MCR_SIS_HI 15

// ----------------------------------------
// apb register byte offsets
// ----------------------------------------
`define MCR_AW 8
`define MCR_OFF_FRAME 8'h00
`define MCR_OFF_STATUS 8'h20
`define MCR_OFF_ACK 8'h24
`define MCR_OFF_CTRL 8'h28
`define MCR_FRAME_MASK 8'he3

// status / control fields
`define MCR_ST_INPROG 0
`define MCR_ST_DOUBLE 1
`define MCR_CTRL_ENABLE 0
`define MCR_CTRL_RESET 32'h00000001

`endif

// ### src/mcr_frame_mem.v
/*
  small frame store: eight 32-bit words, one write port, registered read.
  assumes a single clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
`include "mcr_regs.vh"

module mcr_frame_mem (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // write port
  input wire i_we,
  input wire [`MCR_SLOT_W-1:0] i_waddr,
  input wire [31:0] i_wdata,
  // read port
  input wire [`MCR_SLOT_W-1:0] i_raddr,
  output reg [31:0] o_rdata
);

  reg [31:0] mem_ff [0:`MCR_NSLOT-1];
  integer k;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (k = 0; k < `MCR_NSLOT; k = k + 1) begin
        mem_ff[k] <= 32'h00000000;
      end
      o_rdata <= 32'h00000000;
    end else begin
      if (i_we) begin
        mem_ff[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_ff[i_raddr];
    end
  end

endmodule

// ### src/mcr_core.v
/*
  machine check classification and stack frame capture.
  assumes error strobes and captured state come from cpu logic on i_clk,
  one-cycle error pulses, and an apb master on the same clock.
*/
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "mcr_regs.vh"

// Behaviour
// - mm error in fault handling, translation buffer miss: code 08
// - mm error in fault handling, translation buffer hit: code 09
// - interrupt request at unused priority level: code 0a
// - impossible sequencer state in string copy op: code 0b
// - undefined internal trap code: code 0c
// - undefined control store address reached: code 0d
// - primary cache tag or data parity error on read: code 10
// - local bus read error-terminated or bad parity: code 11
// - local bus error on write or write-buffer clear: code 12
// - undefined local bus state: code 13, unrecoverable
// - operand address register stored at frame offset 8
// - prefetch pointer (last fetch plus four) stored at offset 12
// - clock interrupt enable bit 6 copied to offset 16 bit 22
// - soft interrupt summary bits 15:0 copied to offset 16 low half
// - read error frame taken from the causing instruction
// - machine check code placed in offset 4 bits 15:0
// - offset 4 bit 31 set when no state changed, else clear
// - in-progress flag set on entry, cleared by writing zero to ack
module mcr_core (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // error event strobes from cpu logic
  input wire i_mm_err,
  input wire i_mm_tb_hit,
  input wire i_ipl_unused,
  input wire i_string_bad_state,
  input wire i_trap_undef,
  input wire i_csaddr_undef,
  input wire i_pcache_parity,
  input wire i_bus_rd_err,
  input wire i_bus_wr_err,
  input wire i_bus_undef,
  // state captured with the error
  input wire i_no_state_change,
  input wire [31:0] i_operand_address_reg,
  input wire [31:0] i_instruction_prefetch_pointer,
  input wire [31:0] i_interval_clock_ctl,
  input wire [15:0] i_soft_int_summary,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [`MCR_AW-1:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  // status
  output wire o_mcheck_in_progress,
  output wire o_mcheck_take,
  output wire o_double_error_halt
);

  // ----------------------------------------
  // cause decode
  // ----------------------------------------
  function [7:0] code_of;
    input [`MCR_NCAUSE-1:0] c;
    begin
      if (c[`MCR_C_BUS_UND]) code_of = `MCR_CODE_BUS_UND;
      else if (c[`MCR_C_BUS_WR]) code_of = `MCR_CODE_BUS_WR;
      else if (c[`MCR_C_BUS_RD]) code_of = `MCR_CODE_BUS_RD;
      else if (c[`MCR_C_PCACHE]) code_of = `MCR_CODE_PCACHE;
      else if (c[`MCR_C_CSADDR]) code_of = `MCR_CODE_CSADDR;
      else if (c[`MCR_C_TRAP]) code_of = `MCR_CODE_TRAP;
      else if (c[`MCR_C_STRING]) code_of = `MCR_CODE_STRING;
      else if (c[`MCR_C_IPL]) code_of = `MCR_CODE_IPL;
      else if (c[`MCR_C_MM_HIT]) code_of = `MCR_CODE_MM_HIT;
      else if (c[`MCR_C_MM_MISS]) code_of = `MCR_CODE_MM_MISS;
      else code_of = `MCR_CODE_NONE;
    end
  endfunction

  wire [`MCR_NCAUSE-1:0] cause;
  assign cause[`MCR_C_BUS_UND] = i_bus_undef;
  assign cause[`MCR_C_BUS_WR] = i_bus_wr_err;
  assign cause[`MCR_C_BUS_RD] = i_bus_rd_err;
  assign cause[`MCR_C_PCACHE] = i_pcache_parity;
  assign cause[`MCR_C_CSADDR] = i_csaddr_undef;
  assign cause[`MCR_C_TRAP] = i_trap_undef;
  assign cause[`MCR_C_STRING] = i_string_bad_state;
  assign cause[`MCR_C_IPL] = i_ipl_unused;
  assign cause[`MCR_C_MM_HIT] = i_mm_err & i_mm_tb_hit;
  assign cause[`MCR_C_MM_MISS] = i_mm_err & ~i_mm_tb_hit;

  wire any_err = |cause;

  // ----------------------------------------
  // control and flags
  // ----------------------------------------
  reg [31:0] ctrl_ff;
  reg in_prog_ff;
  reg double_ff;
  reg [2:0] wr_cnt_ff;
  reg [2:0] nxt_wr_cnt;
  reg [31:0] hold_code_ff;
  reg [31:0] hold_addr_ff;
  reg [31:0] hold_pref_ff;
  reg [31:0] hold_ints_ff;

  localparam ST_IDLE = 1'b0;
  localparam ST_WRITE = 1'b1;
  reg state_ff;
  reg nxt_state;

  wire enable = ctrl_ff[`MCR_CTRL_ENABLE];
  wire take = enable & any_err & ~in_prog_ff & (state_ff == ST_IDLE);
  wire dbl = enable & any_err & in_prog_ff;

  // apb decode
  wire apb_acc = i_psel & i_penable;
  wire apb_wr = apb_acc & i_pwrite;
  wire apb_rd = apb_acc & ~i_pwrite;
  wire sel_frame = (i_paddr & `MCR_FRAME_MASK) == `MCR_OFF_FRAME;
  wire sel_status = i_paddr == `MCR_OFF_STATUS;
  wire sel_ack = i_paddr == `MCR_OFF_ACK;
  wire sel_ctrl = i_paddr == `MCR_OFF_CTRL;
  wire sel_any = sel_frame | sel_status | sel_ack | sel_ctrl;
  wire ack_clear = apb_wr & sel_ack & (i_pwdata == 32'h00000000);

  // frame read takes a cycle through the memory register
  reg rd_wait_ff;
  wire frame_rd = apb_rd & sel_frame;
  assign o_pready = ~(frame_rd & ~rd_wait_ff);
  assign o_pslverr = apb_acc & ~sel_any;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_wait_ff <= 1'b0;
    end else begin
      rd_wait_ff <= frame_rd & ~rd_wait_ff;
    end
  end

  // ----------------------------------------
  // capture on entry
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_code_ff <= 32'h00000000;
      hold_addr_ff <= 32'h00000000;
      hold_pref_ff <= 32'h00000000;
      hold_ints_ff <= 32'h00000000;
    end else if (take) begin
      // state of the causing instruction, same cycle as the error
      hold_code_ff <= {i_no_state_change, 15'h0000, 8'h00, code_of(cause)};
      hold_addr_ff <= i_operand_address_reg;
      hold_pref_ff <= i_instruction_prefetch_pointer;
      hold_ints_ff <= {9'h000, i_interval_clock_ctl[`MCR_CLKIE_SRC_BIT],
                       6'h00, i_soft_int_summary[`MCR_SIS_HI:0]};
    end
  end

  // ----------------------------------------
  // frame writer
  // ----------------------------------------
  always @* begin
    nxt_state = state_ff;
    nxt_wr_cnt = wr_cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_state = ST_WRITE;
          nxt_wr_cnt = `MCR_SLOT_COUNT;
        end
      end
      ST_WRITE: begin
        if (wr_cnt_ff == `MCR_SLOT_INTS) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_wr_cnt = wr_cnt_ff + 3'h1;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  reg [31:0] wr_data;
  always @* begin
    case (wr_cnt_ff)
      `MCR_SLOT_COUNT: wr_data = `MCR_BYTE_COUNT;
      `MCR_SLOT_CODE: wr_data = hold_code_ff;
      `MCR_SLOT_ADDR: wr_data = hold_addr_ff;
      `MCR_SLOT_PREF: wr_data = hold_pref_ff;
      `MCR_SLOT_INTS: wr_data = hold_ints_ff;
      default: wr_data = 32'h00000000;
    endcase
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= ST_IDLE;
      wr_cnt_ff <= `MCR_SLOT_COUNT;
    end else begin
      state_ff <= nxt_state;
      wr_cnt_ff <= nxt_wr_cnt;
    end
  end

  // ----------------------------------------
  // flags: set wins over clear
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_prog_ff <= 1'b0;
      double_ff <= 1'b0;
      ctrl_ff <= `MCR_CTRL_RESET;
    end else begin
      if (take) begin
        in_prog_ff <= 1'b1;
      end else if (ack_clear) begin
        in_prog_ff <= 1'b0;
      end
      if (dbl) begin
        double_ff <= 1'b1;
      end
      if (apb_wr & sel_ctrl) begin
        ctrl_ff <= i_pwdata;
      end
    end
  end

  // ----------------------------------------
  // frame memory and read mux
  // ----------------------------------------
  wire [31:0] mem_rdata;
  mcr_frame_mem u_mem (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(state_ff == ST_WRITE),
    .i_waddr(wr_cnt_ff),
    .i_wdata(wr_data),
    .i_raddr(i_paddr[`MCR_SLOT_W+1:2]),
    .o_rdata(mem_rdata)
  );

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    if (apb_rd) begin
      if (sel_frame) begin
        rd_mux = mem_rdata;
      end else if (sel_status) begin
        rd_mux[`MCR_ST_INPROG] = in_prog_ff;
        rd_mux[`MCR_ST_DOUBLE] = double_ff;
      end else if (sel_ctrl) begin
        rd_mux = ctrl_ff;
      end
    end
  end
  assign o_prdata = rd_mux;

  assign o_mcheck_in_progress = in_prog_ff;
  assign o_mcheck_take = take;
  assign o_double_error_halt = double_ff;

endmodule

// ### verification/mcr_core_monitor.sv
/*
  checker for mcr_core: flags, apb timing and frame contents.
  assumes one clock and frame reads only after the frame has settled.
*/
`timescale 1ns/1ps
`include "mcr_regs.vh"
module mcr_core_monitor (
  // clock and reset
  input logic i_clk,
  input logic i_rst_n,
  // error strobes and state
  input logic i_mm_err,
  input logic i_mm_tb_hit,
  input logic i_ipl_unused,
  input logic i_string_bad_state,
  input logic i_trap_undef,
  input logic i_csaddr_undef,
  input logic i_pcache_parity,
  input logic i_bus_rd_err,
  input logic i_bus_wr_err,
  input logic i_bus_undef,
  input logic i_no_state_change,
  input logic [31:0] i_operand_address_reg,
  input logic [31:0] i_instruction_prefetch_pointer,
  input logic [31:0] i_interval_clock_ctl,
  input logic [15:0] i_soft_int_summary,
  // apb
  input logic i_psel,
  input logic i_penable,
  input logic i_pwrite,
  input logic [`MCR_AW-1:0] i_paddr,
  input logic [31:0] i_pwdata,
  input logic [31:0] o_prdata,
  input logic o_pready,
  input logic o_pslverr,
  // status
  input logic o_mcheck_in_progress,
  input logic o_mcheck_take,
  input logic o_double_error_halt
);
  // ----------------------------------------
  // expected frame, captured at each accepted error
  // ----------------------------------------
  logic [31:0] code_ff, addr_ff, pref_ff, ints_ff;
  wire rd_done = i_psel && i_penable && o_pready && !i_pwrite;
  wire any_err = i_mm_err | i_ipl_unused | i_string_bad_state | i_trap_undef
    | i_csaddr_undef | i_pcache_parity | i_bus_rd_err | i_bus_wr_err | i_bus_undef;
  wire [7:0] cause = i_bus_undef ? 8'h13 : i_bus_wr_err ? 8'h12 : i_bus_rd_err ? 8'h11
    : i_pcache_parity ? 8'h10 : i_csaddr_undef ? 8'h0d : i_trap_undef ? 8'h0c
    : i_string_bad_state ? 8'h0b : i_ipl_unused ? 8'h0a : i_mm_tb_hit ? 8'h09 : 8'h08;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      code_ff <= 32'h0;
      addr_ff <= 32'h0;
      pref_ff <= 32'h0;
      ints_ff <= 32'h0;
    end else if (o_mcheck_take) begin
      code_ff <= {i_no_state_change, 23'h0, cause};
      addr_ff <= i_operand_address_reg;
      pref_ff <= i_instruction_prefetch_pointer;
      ints_ff <= {9'h0, i_interval_clock_ctl[6], 6'h0, i_soft_int_summary};
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_CODE:
    assert property (rd_done && i_paddr == 8'h04 |-> o_prdata == code_ff)
    else $error("frame code word differs from the accepted error");
  AST_ADDR:
    assert property (rd_done && i_paddr == 8'h08 |-> o_prdata == addr_ff)
    else $error("frame operand address differs");
  AST_PREF:
    assert property (rd_done && i_paddr == 8'h0c |-> o_prdata == pref_ff)
    else $error("frame prefetch pointer differs");
  AST_INTS:
    assert property (rd_done && i_paddr == 8'h10 |-> o_prdata == ints_ff)
    else $error("frame interrupt word differs");
  AST_RD_WAIT:
    assert property (i_psel && !i_penable && !i_pwrite && i_paddr < 8'h20
      |=> !o_pready ##1 o_pready)
    else $error("frame read wait state wrong");
  AST_TAKE:
    assert property (o_mcheck_take |=> o_mcheck_in_progress)
    else $error("accepted error did not set in progress");
  AST_HOLD:
    assert property (o_mcheck_in_progress |-> !o_mcheck_take)
    else $error("error accepted while in progress");
  AST_DOUBLE:
    assert property (o_mcheck_in_progress && any_err |=> o_double_error_halt)
    else $error("double error not flagged");
  AST_ACK:
    assert property (i_psel && i_penable && o_pready && i_pwrite && i_paddr == 8'h24
      && i_pwdata == 32'h0 && !any_err |=> !o_mcheck_in_progress)
    else $error("zero ack did not clear in progress");
  AST_STATUS:
    assert property (rd_done && i_paddr == 8'h20
      |-> o_prdata == {30'h0, o_double_error_halt, o_mcheck_in_progress})
    else $error("status word differs from flags");
  AST_UNMAP:
    assert property (i_psel && i_penable && i_paddr > 8'h28 |-> o_pslverr && o_pready)
    else $error("unmapped access not refused");
  COV_UND: cover property (o_mcheck_take && i_bus_undef);
  COV_DBL: cover property (o_mcheck_in_progress && any_err);
  COV_ACK: cover property (o_mcheck_in_progress ##1 !o_mcheck_in_progress);
endmodule
bind mcr_core mcr_core_monitor u_mon (.*);

// ### verification/machine_check_reporting_tb.sv
/*
  self-checking bench for mcr_core: codes, frame slots, flags, apb map.
  assumes the design and checker files are compiled ahead of it.
*/
`timescale 1ns/1ps
`include "mcr_regs.vh"
module machine_check_reporting_tb;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [8:0] ev = 9'h0;
  wire i_mm_err, i_ipl_unused, i_string_bad_state, i_trap_undef, i_csaddr_undef;
  wire i_pcache_parity, i_bus_rd_err, i_bus_wr_err, i_bus_undef;
  logic i_mm_tb_hit = 1'b0, i_no_state_change = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h0;
  logic [31:0] i_pwdata = 32'h0, i_operand_address_reg = 32'h0;
  logic [31:0] i_instruction_prefetch_pointer = 32'h0, i_interval_clock_ctl = 32'h0;
  logic [15:0] i_soft_int_summary = 16'h0;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, o_mcheck_in_progress, o_mcheck_take, o_double_error_halt;
  logic [31:0] rdata;
  logic serr;
  int checked = 0;
  int fail_count = 0;
  logic [7:0] codes [10] = '{8'h13, 8'h12, 8'h11, 8'h10, 8'h0d, 8'h0c, 8'h0b, 8'h0a,
    8'h09, 8'h08};
  assign {i_mm_err, i_ipl_unused, i_string_bad_state, i_trap_undef, i_csaddr_undef,
    i_pcache_parity, i_bus_rd_err, i_bus_wr_err, i_bus_undef} = ev;
  mcr_core dut_u (.*);
  always #5 i_clk = ~i_clk;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_sim;
    if (fail_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    // look at pready once settled after the edge; the transfer ends at the next edge
    for (n = 0; n < 20; n++) begin
      #1;
      if (o_pready === 1'b1) begin
        rdata = o_prdata;
        serr = o_pslverr;
        @(posedge i_clk);
        break;
      end
      @(posedge i_clk);
    end
    if (n == 20) begin
      chk("pready wait", 32'h0, 32'h1);
      end_sim;
    end
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rdata, e);
  endtask
  // one error pulse with state derived from k, then time for the frame to settle
  // software side: retry policy, address trust and logging are left to the handler;
  // the bench checks the restart bit and code it relies on, and also the address, prefetch, interrupt and count words
  task automatic raise(input logic [8:0] v, input logic h, input logic [7:0] k);
    @(posedge i_clk);
    ev <= v;
    i_mm_tb_hit <= h;
    i_no_state_change <= k[1];
    i_operand_address_reg <= {24'h400000, k};
    i_instruction_prefetch_pointer <= {20'h08000, k, 4'h4};
    i_interval_clock_ctl <= k[0] ? 32'h40 : 32'hffff_ffbf;
    i_soft_int_summary <= {8'h80, k ^ 8'h01};
    @(posedge i_clk);
    ev <= 9'h0;
    repeat (8) @(posedge i_clk);
  endtask
  task automatic do_reset;
    i_rst_n <= 1'b0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_misc;
    rd("ctrl", 8'h28, 32'h1);
    rd("frame", 8'h04, 32'h0);
    apb(1'b1, 8'h28, 32'h0);
    raise(9'h004, 1'b0, 8'h1);
    rd("off", 8'h20, 32'h0);
    apb(1'b1, 8'h28, 32'h1);
    rd("unmap", 8'h30, 32'h0);
    chk("slverr", {31'h0, serr}, 32'h1);
  endtask
  task automatic t_codes;
    logic [7:0] k;
    for (k = 0; k < 10; k++) begin
      raise(k == 9 ? 9'h100 : 9'h1 << k, k == 8, k);
      rd("code", 8'h04, {k[1], 23'h0, codes[k]});
      chk("code", rdata[7:0], codes[k]);
      chk("restart", rdata[31], k[1]);
      rd("addr", 8'h08, {24'h400000, k});
      rd("pref", 8'h0c, {20'h08000, k, 4'h4});
      rd("ints", 8'h10, {9'h0, k[0], 6'h0, 8'h80, k ^ 8'h01});
      rd("count", 8'h00, 32'h18);
      rd("busy", 8'h20, 32'h1);
      apb(1'b1, 8'h24, 32'h0);
      rd("idle", 8'h20, 32'h0);
    end
  endtask
  task automatic t_prio;
    raise(9'h1ff, 1'b1, 8'h3);
    rd("prio", 8'h04, {1'b1, 23'h0, 8'h13});
    apb(1'b1, 8'h24, 32'h0);
    raise(9'h102, 1'b0, 8'h0);
    rd("prio", 8'h04, 32'h12);
    apb(1'b1, 8'h24, 32'h0);
  endtask
  task automatic t_double;
    raise(9'h080, 1'b0, 8'h2);
    apb(1'b1, 8'h24, 32'h5);
    apb(1'b1, 8'h04, 32'h0);
    rd("busy", 8'h20, 32'h1);
    raise(9'h020, 1'b0, 8'h0);
    rd("dbl", 8'h20, 32'h3);
    rd("kept", 8'h04, {1'b1, 23'h0, 8'h0a});
    apb(1'b1, 8'h24, 32'h0);
    rd("ack", 8'h20, 32'h2);
    do_reset;
    rd("rst", 8'h20, 32'h0);
  endtask
  initial begin
    do_reset;
    t_misc;
    t_codes;
    t_prio;
    t_double;
    end_sim;
  end
endmodule
